// *** rtl/ext_voltage_pkg.sv ***
// Constants and types shared by the external-voltage ADC control block
package ext_voltage_pkg;

    // ****************************************
    // Special-function register addresses
    // ****************************************
    localparam logic [7:0] ADDR_START = 8'hD8;
    localparam logic [7:0] ADDR_RESULT = 8'hEF;
    localparam logic [7:0] ADDR_DELTA = 8'hF3;
    localparam logic [7:0] ADDR_FLAG = 8'hF8;
    localparam logic [7:0] ADDR_PERIOD = 8'hF9;
    localparam logic [7:0] ADDR_ENABLE = 8'hEC;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int GO_BIT = 2;
    localparam int PERIOD_LSB = 4;
    localparam int PERIOD_W = 2;
    localparam int DELTA_LSB = 0;
    localparam int DELTA_W = 3;
    localparam int FLAG_BIT = 3;
    localparam int ENABLE_BIT = 3;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [1:0] INTERVAL_OFF = 2'h0;

    // Input voltage per result step, in microvolts
    localparam int RESULT_UV_PER_LSB = 15300;

    // ****************************************
    // Modes and states
    // ****************************************
    typedef enum logic [1:0] {
        full_power_mode = 2'b00,
        battery_active_mode = 2'b01,
        sleep_background_mode = 2'b10
    } power_mode_e;

    typedef enum logic {
        conv_idle = 1'b0,
        conv_busy = 1'b1
    } conv_state_e;

endpackage : ext_voltage_pkg

// *** rtl/interval_timer.sv ***
// Background measurement interval timer
`timescale 1ns/1ps
`default_nettype none

module interval_timer #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] INTERVAL1 = 24'h0186A0,
    parameter logic [CNT_W-1:0] INTERVAL2 = 24'h0F4240,
    parameter logic [CNT_W-1:0] INTERVAL3 = 24'h989680
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [1:0] interval_sel,
    output logic tick
);

    logic [CNT_W-1:0] count;
    logic [CNT_W-1:0] limit;

    always_comb
    begin
        unique case (interval_sel)
            2'h1: limit = INTERVAL1;
            2'h2: limit = INTERVAL2;
            2'h3: limit = INTERVAL3;
            default: limit = '0;
        endcase
    end

    // Counts only while an interval is selected; code zero keeps it idle
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (interval_sel == ext_voltage_pkg::INTERVAL_OFF)
        begin
            count <= '0;
            tick <= 1'b0;
        end
        else if (count >= limit - 1'b1)
        begin
            count <= '0;
            tick <= 1'b1;
        end
        else
        begin
            count <= count + 1'b1;
            tick <= 1'b0;
        end
    end

endmodule : interval_timer

`default_nettype wire

// *** rtl/ext_voltage_adc_control.sv ***
// External-voltage ADC control with single and background conversions
`timescale 1ns/1ps
`default_nettype none

module ext_voltage_adc_control #(
    parameter int CNT_W = 24,
    parameter logic [CNT_W-1:0] INTERVAL1 = 24'h0186A0,
    parameter logic [CNT_W-1:0] INTERVAL2 = 24'h0F4240,
    parameter logic [CNT_W-1:0] INTERVAL3 = 24'h989680
)
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [7:0] sfr_addr,
    input wire logic sfr_wr,
    input wire logic sfr_rd,
    input wire logic [7:0] sfr_wdata,
    output logic [7:0] sfr_rdata,
    input wire logic [1:0] power_mode,
    output logic adc_start,
    input wire logic adc_done,
    input wire logic [7:0] adc_data,
    output logic ext_voltage_adc_irq,
    output logic power_irq
);

    // ****************************************
    // Declarations
    // ****************************************
    ext_voltage_pkg::conv_state_e state;
    logic ext_voltage_go;
    logic bg_pending;
    logic single_active;
    logic [1:0] ext_voltage_interval;
    logic [2:0] ext_voltage_delta;
    logic ext_voltage_change_flag;
    logic ext_voltage_change_enable;
    logic [7:0] ext_voltage_result;
    logic [7:0] last_irq_value;
    logic tick;
    logic mode_single_ok;
    logic mode_bg_ok;
    logic start_single;
    logic start_bg;
    logic finish;
    logic delta_exceeded;

    function automatic logic [7:0] abs_diff(input logic [7:0] a,
                                            input logic [7:0] b);
        abs_diff = (a >= b) ? a - b : b - a;
    endfunction : abs_diff

    // ****************************************
    // Mode gating
    // ****************************************
    assign mode_single_ok = (power_mode == ext_voltage_pkg::full_power_mode)
        || (power_mode == ext_voltage_pkg::battery_active_mode);
    assign mode_bg_ok = (power_mode == ext_voltage_pkg::full_power_mode)
        || (power_mode == ext_voltage_pkg::sleep_background_mode);

    assign start_single = (state == ext_voltage_pkg::conv_idle)
        && ext_voltage_go && mode_single_ok;
    assign start_bg = (state == ext_voltage_pkg::conv_idle) && !start_single
        && bg_pending && mode_bg_ok
        && (ext_voltage_interval != ext_voltage_pkg::INTERVAL_OFF);
    assign finish = (state == ext_voltage_pkg::conv_busy) && adc_done;
    assign delta_exceeded = abs_diff(adc_data, last_irq_value)
        > {5'h00, ext_voltage_delta};

    // ****************************************
    // Interval timer
    // ****************************************
    interval_timer #(
        .CNT_W(CNT_W),
        .INTERVAL1(INTERVAL1),
        .INTERVAL2(INTERVAL2),
        .INTERVAL3(INTERVAL3)
    ) timer (
        .clock(clock),
        .reset_n(reset_n),
        .interval_sel(ext_voltage_interval),
        .tick(tick)
    );

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_voltage_interval <= ext_voltage_pkg::INTERVAL_OFF;
            ext_voltage_delta <= '0;
            ext_voltage_change_enable <= 1'b0;
        end
        else if (sfr_wr)
        begin
            if (sfr_addr == ext_voltage_pkg::ADDR_PERIOD)
                ext_voltage_interval <= sfr_wdata[ext_voltage_pkg::PERIOD_LSB
                    +: ext_voltage_pkg::PERIOD_W];
            if (sfr_addr == ext_voltage_pkg::ADDR_DELTA)
                ext_voltage_delta <= sfr_wdata[ext_voltage_pkg::DELTA_LSB
                    +: ext_voltage_pkg::DELTA_W];
            if (sfr_addr == ext_voltage_pkg::ADDR_ENABLE)
                ext_voltage_change_enable <=
                    sfr_wdata[ext_voltage_pkg::ENABLE_BIT];
        end
    end

    // ****************************************
    // Conversion requests
    // ****************************************
    // Go bit reads back as one until its conversion finishes
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ext_voltage_go <= 1'b0;
        else if (sfr_wr && sfr_addr == ext_voltage_pkg::ADDR_START
                 && sfr_wdata[ext_voltage_pkg::GO_BIT] && mode_single_ok)
            ext_voltage_go <= 1'b1;
        else if (finish && single_active)
            ext_voltage_go <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            bg_pending <= 1'b0;
        else if (tick && mode_bg_ok)
            bg_pending <= 1'b1;
        else if (start_bg || !mode_bg_ok)
            bg_pending <= 1'b0;
    end

    // ****************************************
    // Conversion sequencer
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state <= ext_voltage_pkg::conv_idle;
            single_active <= 1'b0;
            adc_start <= 1'b0;
        end
        else
        begin
            adc_start <= start_single || start_bg;
            unique case (state)
                ext_voltage_pkg::conv_idle:
                begin
                    if (start_single || start_bg)
                    begin
                        state <= ext_voltage_pkg::conv_busy;
                        single_active <= start_single;
                    end
                end
                ext_voltage_pkg::conv_busy:
                begin
                    if (adc_done)
                        state <= ext_voltage_pkg::conv_idle;
                end
            endcase
        end
    end

    // ****************************************
    // Result, interrupt and change flag
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ext_voltage_result <= ext_voltage_pkg::RESET_BYTE;
            last_irq_value <= ext_voltage_pkg::RESET_BYTE;
            ext_voltage_adc_irq <= 1'b0;
        end
        else if (finish && (single_active || delta_exceeded))
        begin
            ext_voltage_result <= adc_data;
            last_irq_value <= adc_data;
            ext_voltage_adc_irq <= 1'b1;
        end
        else
            ext_voltage_adc_irq <= 1'b0;
    end

    // Cleared by writing zero to its bit; a change in the same cycle wins
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            ext_voltage_change_flag <= 1'b0;
        else if (finish && !single_active && delta_exceeded)
            ext_voltage_change_flag <= 1'b1;
        else if (sfr_wr && sfr_addr == ext_voltage_pkg::ADDR_FLAG
                 && !sfr_wdata[ext_voltage_pkg::FLAG_BIT])
            ext_voltage_change_flag <= 1'b0;
    end

    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            power_irq <= 1'b0;
        else
            power_irq <= ext_voltage_change_flag
                && ext_voltage_change_enable;
    end

    // ****************************************
    // Register read port
    // ****************************************
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            sfr_rdata <= ext_voltage_pkg::RESET_BYTE;
        else if (sfr_rd)
        begin
            sfr_rdata <= ext_voltage_pkg::RESET_BYTE;
            unique case (sfr_addr)
                ext_voltage_pkg::ADDR_RESULT:
                    sfr_rdata <= ext_voltage_result;
                ext_voltage_pkg::ADDR_START:
                    sfr_rdata[ext_voltage_pkg::GO_BIT] <= ext_voltage_go;
                ext_voltage_pkg::ADDR_PERIOD:
                    sfr_rdata[ext_voltage_pkg::PERIOD_LSB
                        +: ext_voltage_pkg::PERIOD_W] <= ext_voltage_interval;
                ext_voltage_pkg::ADDR_DELTA:
                    sfr_rdata[ext_voltage_pkg::DELTA_LSB
                        +: ext_voltage_pkg::DELTA_W] <= ext_voltage_delta;
                ext_voltage_pkg::ADDR_FLAG:
                    sfr_rdata[ext_voltage_pkg::FLAG_BIT] <=
                        ext_voltage_change_flag;
                ext_voltage_pkg::ADDR_ENABLE:
                    sfr_rdata[ext_voltage_pkg::ENABLE_BIT] <=
                        ext_voltage_change_enable;
                default:
                    sfr_rdata <= ext_voltage_pkg::RESET_BYTE;
            endcase
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    a_result_on_irq: assert property (
        @(posedge clock) disable iff (!reset_n)
        $changed(ext_voltage_result) |-> ext_voltage_adc_irq)
        else $error("result changed without ADC interrupt");

    a_single_irq_done: assert property (
        @(posedge clock) disable iff (!reset_n)
        finish && single_active |=> ext_voltage_adc_irq
            && ext_voltage_result == $past(adc_data))
        else $error("single conversion did not interrupt with result");

    a_delta_flag_set: assert property (
        @(posedge clock) disable iff (!reset_n)
        finish && !single_active && delta_exceeded
            |=> ext_voltage_change_flag && ext_voltage_adc_irq)
        else $error("delta exceeded without change flag");

    a_no_delta_no_irq: assert property (
        @(posedge clock) disable iff (!reset_n)
        finish && !single_active && !delta_exceeded
            |=> !ext_voltage_adc_irq && $stable(ext_voltage_result))
        else $error("background irq without delta exceeded");

    a_power_irq_gate: assert property (
        @(posedge clock) disable iff (!reset_n)
        ##1 power_irq == $past(ext_voltage_change_flag
            && ext_voltage_change_enable))
        else $error("power interrupt does not follow flag and enable");

    a_bg_off_interval: assert property (
        @(posedge clock) disable iff (!reset_n)
        start_bg |-> ext_voltage_interval != ext_voltage_pkg::INTERVAL_OFF)
        else $error("background conversion with interval off");

    a_battery_no_bg: assert property (
        @(posedge clock) disable iff (!reset_n)
        adc_start && !single_active |-> $past(power_mode)
            != ext_voltage_pkg::battery_active_mode)
        else $error("background conversion in battery mode");

    a_sleep_no_go: assert property (
        @(posedge clock) disable iff (!reset_n)
        power_mode == ext_voltage_pkg::sleep_background_mode && !ext_voltage_go
            |=> !ext_voltage_go)
        else $error("go bit accepted in sleep mode");

    a_go_starts: assert property (
        @(posedge clock) disable iff (!reset_n)
        ext_voltage_go && state == ext_voltage_pkg::conv_idle && mode_single_ok
            |=> adc_start && single_active)
        else $error("single conversion did not start");

    a_result_write_ro: assert property (
        @(posedge clock) disable iff (!reset_n)
        sfr_wr && sfr_addr == ext_voltage_pkg::ADDR_RESULT && !finish
            |=> $stable(ext_voltage_result))
        else $error("write disturbed result register");

endmodule : ext_voltage_adc_control

`default_nettype wire

// *** verif/tb_top.sv ***
// Self-checking bench for the external-voltage ADC control block
`timescale 1ns/1ps
`default_nettype none

module tb_top;

    // ****************************************
    // Signals and design instance
    // ****************************************
    localparam logic [23:0] IV1 = 24'h000014;
    localparam logic [23:0] IV2 = 24'h000028;
    localparam logic [23:0] IV3 = 24'h00003C;
    localparam int LAT = 3;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic [7:0] sfr_addr = 8'h00;
    logic sfr_wr = 1'b0;
    logic sfr_rd = 1'b0;
    logic [7:0] sfr_wdata = 8'h00;
    logic [7:0] sfr_rdata;
    logic [1:0] power_mode = 2'h0;
    logic adc_start;
    logic adc_done = 1'b0;
    logic [7:0] adc_data = 8'h00;
    logic ext_voltage_adc_irq;
    logic power_irq;
    logic [7:0] conv_data = 8'h00;
    logic [23:0] rows [8];
    int fails = 0;
    int checked = 0;
    int start_count = 0;
    int irq_count = 0;
    int exp_irq = 0;
    int cyc = 0;
    int last = 0;
    int gap = 0;
    int wait_cnt = 0;
    int base = 0;
    logic pend = 1'b0;

    ext_voltage_adc_control #(
        .CNT_W(24),
        .INTERVAL1(IV1),
        .INTERVAL2(IV2),
        .INTERVAL3(IV3)
    ) i_ext_voltage_adc_control (
        .clock(clock),
        .reset_n(reset_n),
        .sfr_addr(sfr_addr),
        .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd),
        .sfr_wdata(sfr_wdata),
        .sfr_rdata(sfr_rdata),
        .power_mode(power_mode),
        .adc_start(adc_start),
        .adc_done(adc_done),
        .adc_data(adc_data),
        .ext_voltage_adc_irq(ext_voltage_adc_irq),
        .power_irq(power_irq)
    );

    initial
    begin
        forever #5 clock = ~clock;
    end

    // ****************************************
    // Converter stand-in and monitors
    // ****************************************
    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        adc_done <= 1'b0;
        adc_data <= ~conv_data;
        if (ext_voltage_irq_seen()) irq_count <= irq_count + 1;
        if (adc_start === 1'b1)
        begin
            pend <= 1'b1;
            wait_cnt <= LAT;
            start_count <= start_count + 1;
            gap <= cyc - last;
            last <= cyc;
        end
        else if (pend && wait_cnt == 0)
        begin
            adc_done <= 1'b1;
            adc_data <= conv_data;
            pend <= 1'b0;
        end
        else if (pend) wait_cnt <= wait_cnt - 1;
    end

    function automatic bit ext_voltage_irq_seen();
        return ext_voltage_adc_irq === 1'b1;
    endfunction : ext_voltage_irq_seen

    // ****************************************
    // Tasks
    // ****************************************
    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
            fails++;
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        sfr_wr <= 1'b1;
        sfr_addr <= a;
        sfr_wdata <= d;
        @(posedge clock);
        sfr_wr <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clock);
        sfr_rd <= 1'b1;
        sfr_addr <= a;
        @(posedge clock);
        sfr_rd <= 1'b0;
        @(posedge clock);
        check(sfr_rdata, exp);
    endtask : rdc

    task automatic wait_start(input int target);
        for (int i = 0; i < 300 && start_count < target; i++)
            @(posedge clock);
        if (start_count < target)
        begin
            fails++;
            test_done();
        end
        repeat (LAT + 5) @(posedge clock);
    endtask : wait_start

    task automatic conv_check(input logic [7:0] res);
        check(8'(irq_count), 8'(exp_irq));
        rdc(8'hEF, res);
    endtask : conv_check

    task automatic quiet_outputs();
        check(sfr_rdata, 8'h00);
        check({5'h00, adc_start, ext_voltage_adc_irq, power_irq}, 8'h00);
    endtask : quiet_outputs

    // ****************************************
    // Main sequence
    // ****************************************
    initial
    begin
        rows = '{24'hEFFF00, 24'hECFF08, 24'hEC0000, 24'hF3FF07,
                 24'hF30000, 24'h55FF00, 24'hF8FF00, 24'hF90000};
        repeat (4) @(posedge clock);
        quiet_outputs();
        @(posedge clock);
        reset_n <= 1'b1;
        foreach (rows[i]) rdc(rows[i][23:16], 8'h00);
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdc(rows[i][23:16], rows[i][7:0]);
        end
        conv_data <= 8'h5A;
        wr(8'hD8, 8'h04);
        rdc(8'hD8, 8'h04);
        wait_start(1);
        exp_irq++;
        conv_check(8'h5A);
        rdc(8'hD8, 8'h00);
        power_mode <= 2'h1;
        conv_data <= 8'h33;
        wr(8'hD8, 8'h04);
        wait_start(2);
        exp_irq++;
        conv_check(8'h33);
        power_mode <= 2'h2;
        wr(8'hD8, 8'h04);
        repeat (20) @(posedge clock);
        check(8'(start_count), 8'h02);
        conv_check(8'h33);
        power_mode <= 2'h0;
        wr(8'hF3, 8'h02);
        conv_data <= 8'h35;
        wr(8'hF9, 8'h10);
        wait_start(3);
        conv_check(8'h33);
        rdc(8'hF8, 8'h00);
        conv_data <= 8'h36;
        wait_start(start_count + 1);
        exp_irq++;
        conv_check(8'h36);
        rdc(8'hF8, 8'h08);
        check({7'h00, power_irq}, 8'h00);
        wr(8'hEC, 8'h08);
        repeat (2) @(posedge clock);
        check({7'h00, power_irq}, 8'h01);
        wr(8'hF8, 8'h00);
        repeat (2) @(posedge clock);
        check({7'h00, power_irq}, 8'h00);
        conv_data <= 8'h30;
        wait_start(start_count + 1);
        exp_irq++;
        conv_check(8'h30);
        for (int k = 1; k <= 3; k++)
        begin
            wr(8'hF9, 8'(k << 4));
            wait_start(start_count + 2);
            check(8'(gap), (k == 1) ? IV1[7:0] : (k == 2) ? IV2[7:0]
                  : IV3[7:0]);
        end
        conv_check(8'h30);
        power_mode <= 2'h1;
        base = start_count;
        repeat (130) @(posedge clock);
        check(8'(start_count - base), 8'h00);
        power_mode <= 2'h2;
        conv_data <= 8'h50;
        wait_start(base + 1);
        exp_irq++;
        conv_check(8'h50);
        @(posedge clock);
        reset_n <= 1'b0;
        power_mode <= 2'h0;
        @(posedge clock);
        quiet_outputs();
        @(posedge clock);
        reset_n <= 1'b1;
        base = start_count;
        repeat (80) @(posedge clock);
        check(8'(start_count - base), 8'h00);
        rdc(8'hF9, 8'h00);
        rdc(8'hEF, 8'h00);
        test_done();
    end

endmodule : tb_top

`default_nettype wire
